/* src/lac_pkg.sv */
package lac_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_LAMP_CFG = 4'h1;
    localparam logic [3:0] ADDR_CMD = 4'h2;
    localparam logic [3:0] ADDR_STATUS = 4'h3;
    localparam logic [3:0] ADDR_IRQ_STAT = 4'h4;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'h5;
    localparam logic [3:0] ADDR_LATCH = 4'h6;

    // ctrl field positions
    localparam int CTRL_REMOTE_PERMIT = 0;
    localparam int CTRL_SCOPE_LSB = 1;
    localparam int CTRL_PW_EMPTY = 4;
    localparam int CTRL_SG_SEL_LSB = 8;

    // command bits in ADDR_CMD writes
    localparam int CMD_SYS_LAMP = 0;
    localparam int CMD_ALL_LAMPS = 1;
    localparam int CMD_ALL_RELAYS = 2;
    localparam int CMD_ALL_SCADA = 3;
    localparam int CMD_SG_TRIP = 4;
    localparam int CMD_EVERYTHING = 5;
    localparam int CMD_REMOTE = 8;
    localparam int CMD_CONFIRM = 9;
    localparam int CMD_PW_OK = 10;

    // irq bit positions
    localparam int IRQ_ACK_DONE = 0;
    localparam int IRQ_LONG = 1;
    localparam int IRQ_REFUSED = 2;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_HZ = 40_000_000;
    localparam int LONG_PRESS_MS = 1000;
    localparam int LONG_PRESS_CYC = CLK_HZ / 1000 * LONG_PRESS_MS;
    localparam int LAMP_TEST_MS = 1000;
    localparam int LAMP_TEST_CYC = CLK_HZ / 1000 * LAMP_TEST_MS;

    // reset values
    localparam logic [31:0] CTRL_RESET = 32'h0000_0002;

    typedef enum logic [2:0] {
        LAC_SCOPE_NOTHING = 3'h0,
        LAC_SCOPE_LAMPS_NOPW = 3'h1,
        LAC_SCOPE_LAMPS = 3'h2,
        LAC_SCOPE_LAMPS_RELAYS = 3'h3,
        LAC_SCOPE_EVERYTHING = 3'h4
    } lac_scope_t;

    typedef enum logic [1:0] {
        LAC_LT_IDLE = 2'h0,
        LAC_LT_RED = 2'h1,
        LAC_LT_GREEN = 2'h2
    } lac_lt_state_t;

    typedef enum logic [1:0] {
        LAC_KEY_IDLE = 2'h0,
        LAC_KEY_TIMING = 2'h1,
        LAC_KEY_HELD = 2'h2
    } lac_key_state_t;

    // one clear request
    typedef struct packed {
        logic sys_lamp;
        logic lamps;
        logic relays;
        logic scada;
        logic trip;
    } lac_clear_t;

endpackage : lac_pkg

/* src/lac_top.sv */
// Behaviour
// - protection alarm clears alarm-latched lamps
// - alarm clearing selected per lamp
// - remote requests need remote permit
// - separate commands per clear category
// - combined command clears everything (code clears lamps, relays, scada and trips, not the system warning)
// - clear key inert in setting mode
// - short press opens selection, confirm clears
// - long press clears scope immediately
// - scope nothing: long press does nothing
// - default scope: lamps, no password
// - lamps scope needs password
// - lamps and relays need password
// - everything scope needs password
// - lamp clear starts red/green test
// - other clears may need password
// - empty level-one password skips prompt
// - relay clear waits release delay
// - no permit: external requests ignored
//
// The implementer's own choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module lac_top #(
    parameter int N_LAMPS = 16,
    parameter int N_RELAYS = 8,
    parameter int N_SCADA = 8,
    parameter int N_SG = 4,
    parameter int LONG_CYC = lac_pkg::LONG_PRESS_CYC,
    parameter int TEST_CYC = lac_pkg::LAMP_TEST_CYC
) (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic [3:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rdata_out,
    input wire logic prot_alarm_in,
    input wire logic clear_key_in,
    input wire logic setting_mode_in,
    input wire logic [N_LAMPS-1:0] lamp_set_in,
    input wire logic [N_RELAYS-1:0] relay_set_in,
    input wire logic [N_RELAYS-1:0] relay_off_done_in,
    input wire logic [N_SCADA-1:0] scada_set_in,
    input wire logic [N_SG-1:0] trip_set_in,
    input wire logic sys_warn_set_in,
    output logic [N_LAMPS-1:0] lamp_latch_out,
    output logic [N_RELAYS-1:0] relay_latch_out,
    output logic [N_SCADA-1:0] scada_latch_out,
    output logic [N_SG-1:0] trip_latch_out,
    output logic sys_warn_out,
    output logic menu_open_out,
    output logic pw_prompt_out,
    output logic lamp_test_red_out,
    output logic lamp_test_green_out,
    output logic irq_out
);

    // ****************************************
    // configuration registers
    // ****************************************
    logic [31:0] ctrl;
    logic [N_LAMPS-1:0] lamp_alarm_ack;
    logic [2:0] irq_mask;
    logic [2:0] irq_stat;
    logic remote_permit;
    logic pw_empty;
    lac_pkg::lac_scope_t scope;
    logic [1:0] sg_sel;

    assign remote_permit = ctrl[lac_pkg::CTRL_REMOTE_PERMIT];
    assign scope = lac_pkg::lac_scope_t'(ctrl[lac_pkg::CTRL_SCOPE_LSB +: 3]);
    assign pw_empty = ctrl[lac_pkg::CTRL_PW_EMPTY];
    assign sg_sel = ctrl[lac_pkg::CTRL_SG_SEL_LSB +: 2];

    logic cmd_wr;
    assign cmd_wr = wr_in && (addr_in == lac_pkg::ADDR_CMD);

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl <= lac_pkg::CTRL_RESET;
            lamp_alarm_ack <= '0;
            irq_mask <= 3'h0;
        end else if (wr_in) begin
            if (addr_in == lac_pkg::ADDR_CTRL) begin
                ctrl <= wdata_in;
            end else if (addr_in == lac_pkg::ADDR_LAMP_CFG) begin
                lamp_alarm_ack <= wdata_in[N_LAMPS-1:0];
            end else if (addr_in == lac_pkg::ADDR_IRQ_MASK) begin
                irq_mask <= wdata_in[2:0];
            end
        end
    end

    // ****************************************
    // clear key timing
    // ****************************************
    lac_pkg::lac_key_state_t key_st;
    logic [31:0] key_cnt;
    logic short_press;
    logic long_press;

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            key_st <= lac_pkg::LAC_KEY_IDLE;
            key_cnt <= 32'h0;
            short_press <= 1'b0;
            long_press <= 1'b0;
        end else begin
            short_press <= 1'b0;
            long_press <= 1'b0;
            case (key_st)
                lac_pkg::LAC_KEY_IDLE: begin
                    key_cnt <= 32'h0;
                    if (clear_key_in && !setting_mode_in) begin
                        key_st <= lac_pkg::LAC_KEY_TIMING;
                    end
                end
                lac_pkg::LAC_KEY_TIMING: begin
                    if (!clear_key_in) begin
                        short_press <= 1'b1;
                        key_st <= lac_pkg::LAC_KEY_IDLE;
                    end else if (key_cnt == 32'(LONG_CYC - 2)) begin
                        long_press <= 1'b1;
                        key_st <= lac_pkg::LAC_KEY_HELD;
                    end else begin
                        key_cnt <= key_cnt + 32'h1;
                    end
                end
                lac_pkg::LAC_KEY_HELD: begin
                    if (!clear_key_in) begin
                        key_st <= lac_pkg::LAC_KEY_IDLE;
                    end
                end
                default: key_st <= lac_pkg::LAC_KEY_IDLE;
            endcase
        end
    end

    // ****************************************
    // request gathering
    // ****************************************
    lac_pkg::lac_clear_t sel;
    lac_pkg::lac_clear_t pend;
    lac_pkg::lac_clear_t next_clear;
    logic remote_req;
    logic remote_ok;
    logic pw_ok;
    logic refused;

    assign remote_req = cmd_wr && wdata_in[lac_pkg::CMD_REMOTE];
    assign remote_ok = !remote_req || remote_permit;
    assign pw_ok = cmd_wr && wdata_in[lac_pkg::CMD_PW_OK];

    function automatic lac_pkg::lac_clear_t cmd_decode(input logic [31:0] w);
        lac_pkg::lac_clear_t c;
        c = '0;
        c.sys_lamp = w[lac_pkg::CMD_SYS_LAMP];
        c.lamps = w[lac_pkg::CMD_ALL_LAMPS];
        c.relays = w[lac_pkg::CMD_ALL_RELAYS];
        c.scada = w[lac_pkg::CMD_ALL_SCADA];
        c.trip = w[lac_pkg::CMD_SG_TRIP];
        if (w[lac_pkg::CMD_EVERYTHING]) begin
            c.lamps = 1'b1;
            c.relays = 1'b1;
            c.scada = 1'b1;
            c.trip = 1'b1;
        end
        return c;
    endfunction : cmd_decode

    function automatic lac_pkg::lac_clear_t scope_decode(
        input lac_pkg::lac_scope_t s);
        lac_pkg::lac_clear_t c;
        c = '0;
        case (s)
            lac_pkg::LAC_SCOPE_LAMPS_NOPW,
            lac_pkg::LAC_SCOPE_LAMPS: c.lamps = 1'b1;
            lac_pkg::LAC_SCOPE_LAMPS_RELAYS: begin
                c.lamps = 1'b1;
                c.relays = 1'b1;
            end
            lac_pkg::LAC_SCOPE_EVERYTHING: begin
                c.lamps = 1'b1;
                c.relays = 1'b1;
                c.scada = 1'b1;
                c.trip = 1'b1;
            end
            default: c = '0;
        endcase
        return c;
    endfunction : scope_decode

    function automatic logic needs_pw(input lac_pkg::lac_clear_t c,
        input logic nopw_lamps, input logic empty);
        logic lamp_need;
        logic other_need;
        lamp_need = (c.lamps || c.sys_lamp) && !nopw_lamps;
        other_need = (c.relays || c.scada || c.trip) && !empty;
        return lamp_need || other_need;
    endfunction : needs_pw

    // selection menu, password wait and clear issue
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            sel <= '0;
            pend <= '0;
            next_clear <= '0;
            menu_open_out <= 1'b0;
            pw_prompt_out <= 1'b0;
            refused <= 1'b0;
        end else begin
            next_clear <= '0;
            refused <= 1'b0;
            if (short_press) begin
                menu_open_out <= 1'b1;
                sel <= '0;
            end
            if (cmd_wr && !remote_ok) begin
                refused <= 1'b1;
            end else if (pw_prompt_out) begin
                if (pw_ok) begin
                    next_clear <= pend;
                    pw_prompt_out <= 1'b0;
                end
            end else if (long_press) begin
                if (scope_decode(scope) != '0) begin
                    if (needs_pw(scope_decode(scope),
                        scope == lac_pkg::LAC_SCOPE_LAMPS_NOPW, pw_empty)) begin
                        pend <= scope_decode(scope);
                        pw_prompt_out <= 1'b1;
                    end else begin
                        next_clear <= scope_decode(scope);
                    end
                end
            end else if (cmd_wr && menu_open_out
                && !wdata_in[lac_pkg::CMD_CONFIRM]) begin
                sel <= sel | cmd_decode(wdata_in);
            end else if (cmd_wr && menu_open_out) begin
                menu_open_out <= 1'b0;
                if (needs_pw(sel, 1'b0, pw_empty)) begin
                    pend <= sel;
                    pw_prompt_out <= 1'b1;
                end else begin
                    next_clear <= sel;
                end
            end else if (cmd_wr && !wdata_in[lac_pkg::CMD_PW_OK]) begin
                if (needs_pw(cmd_decode(wdata_in), 1'b0, pw_empty)) begin
                    pend <= cmd_decode(wdata_in);
                    pw_prompt_out <= 1'b1;
                end else begin
                    next_clear <= cmd_decode(wdata_in);
                end
            end
        end
    end

    // ****************************************
    // latched states
    // ****************************************
    logic alarm_d;
    logic alarm_rise;
    logic [N_RELAYS-1:0] relay_clr_pend;
    assign alarm_rise = prot_alarm_in && !alarm_d;

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            alarm_d <= 1'b0;
            lamp_latch_out <= '0;
            sys_warn_out <= 1'b0;
            scada_latch_out <= '0;
            trip_latch_out <= '0;
        end else begin
            alarm_d <= prot_alarm_in;
            // set wins over clear
            if (next_clear.lamps) begin
                lamp_latch_out <= lamp_set_in;
            end else if (alarm_rise) begin
                lamp_latch_out <= (lamp_latch_out & ~lamp_alarm_ack)
                    | lamp_set_in;
            end else begin
                lamp_latch_out <= lamp_latch_out | lamp_set_in;
            end
            sys_warn_out <= (sys_warn_out && !next_clear.sys_lamp)
                || sys_warn_set_in;
            scada_latch_out <= (next_clear.scada ? '0 : scada_latch_out)
                | scada_set_in;
            if (next_clear.trip) begin
                trip_latch_out <= trip_set_in;
            end else begin
                trip_latch_out <= trip_latch_out | trip_set_in;
            end
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            relay_clr_pend <= '0;
            relay_latch_out <= '0;
        end else begin
            relay_clr_pend <= (relay_clr_pend
                | (next_clear.relays ? relay_latch_out : '0))
                & ~relay_off_done_in;
            relay_latch_out <= (relay_latch_out & ~((relay_clr_pend
                | (next_clear.relays ? relay_latch_out : '0))
                & relay_off_done_in)) | relay_set_in;
        end
    end

    // ****************************************
    // lamp test
    // ****************************************
    lac_pkg::lac_lt_state_t lt_st;
    logic [31:0] lt_cnt;

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            lt_st <= lac_pkg::LAC_LT_IDLE;
            lt_cnt <= 32'h0;
            lamp_test_red_out <= 1'b0;
            lamp_test_green_out <= 1'b0;
        end else if (next_clear.lamps) begin
            lt_st <= lac_pkg::LAC_LT_RED;
            lt_cnt <= 32'h0;
            lamp_test_red_out <= 1'b1;
            lamp_test_green_out <= 1'b0;
        end else begin
            case (lt_st)
                lac_pkg::LAC_LT_RED: begin
                    if (lt_cnt == 32'(TEST_CYC - 1)) begin
                        lt_cnt <= 32'h0;
                        lt_st <= lac_pkg::LAC_LT_GREEN;
                        lamp_test_red_out <= 1'b0;
                        lamp_test_green_out <= 1'b1;
                    end else begin
                        lt_cnt <= lt_cnt + 32'h1;
                    end
                end
                lac_pkg::LAC_LT_GREEN: begin
                    if (lt_cnt == 32'(TEST_CYC - 1)) begin
                        lt_st <= lac_pkg::LAC_LT_IDLE;
                        lamp_test_green_out <= 1'b0;
                    end else begin
                        lt_cnt <= lt_cnt + 32'h1;
                    end
                end
                default: begin
                    lt_cnt <= 32'h0;
                end
            endcase
        end
    end

    // ****************************************
    // interrupts and read data
    // ****************************************
    logic [2:0] irq_ev;
    assign irq_ev = {refused, long_press, next_clear != '0};

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            irq_stat <= 3'h0;
            irq_out <= 1'b0;
        end else begin
            if (rd_in && addr_in == lac_pkg::ADDR_IRQ_STAT) begin
                irq_stat <= irq_ev;
            end else begin
                irq_stat <= irq_stat | irq_ev;
            end
            irq_out <= |((irq_stat | irq_ev) & irq_mask);
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_out <= 32'h0;
        end else if (rd_in) begin
            if (addr_in == lac_pkg::ADDR_CTRL) begin
                rdata_out <= ctrl;
            end else if (addr_in == lac_pkg::ADDR_LAMP_CFG) begin
                rdata_out <= 32'(lamp_alarm_ack);
            end else if (addr_in == lac_pkg::ADDR_STATUS) begin
                rdata_out <= {24'h0, sel, lt_st, pw_prompt_out};
            end else if (addr_in == lac_pkg::ADDR_IRQ_STAT) begin
                rdata_out <= {29'h0, irq_stat};
            end else if (addr_in == lac_pkg::ADDR_IRQ_MASK) begin
                rdata_out <= {29'h0, irq_mask};
            end else if (addr_in == lac_pkg::ADDR_LATCH) begin
                rdata_out <= {16'(lamp_latch_out), 8'(relay_latch_out),
                    8'(scada_latch_out)};
            end else begin
                rdata_out <= 32'h0;
            end
        end else begin
            rdata_out <= 32'h0;
        end
    end

endmodule : lac_top
`default_nettype wire

/* test/lac_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module lac_checker #(
    parameter int N_LAMPS = 16,
    parameter int N_RELAYS = 8,
    parameter int LONG_CYC = 20,
    parameter int TEST_CYC = 20
) (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic rd_in,
    input wire logic [31:0] rdata_out,
    input wire logic clear_key_in,
    input wire logic setting_mode_in,
    input wire logic [N_LAMPS-1:0] lamp_set_in,
    input wire logic [N_RELAYS-1:0] relay_off_done_in,
    input wire logic sys_warn_set_in,
    input wire logic [N_LAMPS-1:0] lamp_latch_out,
    input wire logic [N_RELAYS-1:0] relay_latch_out,
    input wire logic sys_warn_out,
    input wire logic menu_open_out,
    input wire logic lamp_test_red_out,
    input wire logic lamp_test_green_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    int key_cnt;
    int red_cnt;
    int grn_cnt;
    // ****
    // cycle counters
    // ****
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            key_cnt <= 0;
            red_cnt <= 0;
            grn_cnt <= 0;
        end else begin
            key_cnt <= clear_key_in ? key_cnt + 1 : 0;
            red_cnt <= lamp_test_red_out ? red_cnt + 1 : 0;
            grn_cnt <= lamp_test_green_out ? grn_cnt + 1 : 0;
        end
    end
    sequence s_short_rel;
        $fell(clear_key_in) && !setting_mode_in && key_cnt < LONG_CYC - 1;
    endsequence
    sequence s_red_end;
        $fell(lamp_test_red_out);
    endsequence
    // ****
    // assertions
    // ****
    a_rdata_quiet: assert property (!$past(rd_in) |-> rdata_out == 32'h0)
        else $error("read data outside read slot");
    a_red_length: assert property (
        s_red_end |-> red_cnt == TEST_CYC && lamp_test_green_out)
        else $error("red phase length or handover wrong");
    a_green_length: assert property (
        $fell(lamp_test_green_out) |-> grn_cnt == TEST_CYC)
        else $error("green phase length wrong");
    a_test_excl: assert property (
        !(lamp_test_red_out && lamp_test_green_out))
        else $error("red and green together");
    a_green_after: assert property (
        $rose(lamp_test_green_out) |-> $past(lamp_test_red_out))
        else $error("green without red");
    a_short_menu: assert property (s_short_rel |=> ##1 menu_open_out)
        else $error("short press did not open menu");
    a_mode_inert: assert property (
        setting_mode_in && !menu_open_out |=> !menu_open_out)
        else $error("menu opened in setting mode");
    a_relay_wait: assert property (
        (~relay_latch_out & $past(relay_latch_out)
         & ~$past(relay_off_done_in)) == '0)
        else $error("relay cleared before release delay");
    a_lamp_set: assert property (|lamp_set_in |=>
        (lamp_latch_out & $past(lamp_set_in)) == $past(lamp_set_in))
        else $error("lamp set not latched");
    a_warn_set: assert property (sys_warn_set_in |=> sys_warn_out)
        else $error("warning set not latched");
endmodule : lac_checker
bind lac_top lac_checker #(.N_LAMPS(N_LAMPS), .N_RELAYS(N_RELAYS),
    .LONG_CYC(LONG_CYC), .TEST_CYC(TEST_CYC)) u_chk (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .clear_key_in(clear_key_in),
    .setting_mode_in(setting_mode_in), .lamp_set_in(lamp_set_in),
    .relay_off_done_in(relay_off_done_in),
    .sys_warn_set_in(sys_warn_set_in), .lamp_latch_out(lamp_latch_out),
    .relay_latch_out(relay_latch_out), .sys_warn_out(sys_warn_out),
    .menu_open_out(menu_open_out), .lamp_test_red_out(lamp_test_red_out),
    .lamp_test_green_out(lamp_test_green_out));
`default_nettype wire

/* test/lac_panel_model.sv */
`timescale 1ns/1ps
`default_nettype none
module lac_panel_model #(
    parameter int N_RELAYS = 8,
    parameter int REL_DLY = 12
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic go_in,
    input wire logic [7:0] len_in,
    input wire logic [N_RELAYS-1:0] relay_latch_in,
    output logic key_out,
    output logic [N_RELAYS-1:0] off_done_out
);
    int left;
    int rc [N_RELAYS];
    // ****
    // clear key held for len_in cycles
    // ****
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            left <= 0;
        end else begin
            left <= go_in ? int'(len_in) : (left > 0 ? left - 1 : 0);
        end
    end
    assign key_out = left > 0;
    // ****
    // relay release delay per output
    // ****
    always_ff @(posedge clk_in or posedge rst_in) begin
        for (int i = 0; i < N_RELAYS; i++) begin
            if (rst_in || relay_latch_in[i]) begin
                rc[i] <= 0;
            end else if (rc[i] < REL_DLY) begin
                rc[i] <= rc[i] + 1;
            end
        end
    end
    always_comb begin
        for (int i = 0; i < N_RELAYS; i++) begin
            off_done_out[i] = rc[i] >= REL_DLY;
        end
    end
endmodule : lac_panel_model
`default_nettype wire

/* test/latch_acknowledge_control_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module latch_acknowledge_control_tb_top;
    localparam int TC = 20;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic alarm = 1'b0;
    logic mode = 1'b0;
    logic go = 1'b0;
    logic [7:0] len = 8'h0;
    logic [15:0] lset = 16'h0;
    logic [7:0] rset = 8'h0;
    logic [7:0] sset = 8'h0;
    logic [3:0] tset = 4'h0;
    logic wset = 1'b0;
    logic [31:0] rdata;
    logic [15:0] ll;
    logic [7:0] rl, sl, rdone;
    logic [3:0] tl;
    logic warn, menu, pwp, red, grn, irq, key;
    int num_errors = 0;
    int check_count = 0;
    lac_top #(.LONG_CYC(20), .TEST_CYC(TC)) dut (
        .sys_clk_in(clk), .rst_in(rst), .addr_in(addr), .wdata_in(wdata),
        .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .prot_alarm_in(alarm),
        .clear_key_in(key), .setting_mode_in(mode), .lamp_set_in(lset),
        .relay_set_in(rset), .relay_off_done_in(rdone),
        .scada_set_in(sset), .trip_set_in(tset), .sys_warn_set_in(wset),
        .lamp_latch_out(ll), .relay_latch_out(rl), .scada_latch_out(sl),
        .trip_latch_out(tl), .sys_warn_out(warn), .menu_open_out(menu),
        .pw_prompt_out(pwp), .lamp_test_red_out(red),
        .lamp_test_green_out(grn), .irq_out(irq));
    lac_panel_model u_panel (
        .clk_in(clk), .rst_in(rst), .go_in(go), .len_in(len),
        .relay_latch_in(rset), .key_out(key), .off_done_out(rdone));
    initial begin
        forever #12.5 clk = ~clk;
    end
    // ****
    // helpers
    // ****
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg
    task automatic issue(input logic [31:0] d);
        wr_reg(lac_pkg::ADDR_CMD, d);
        cyc(2);
        if (pwp === 1'b1) wr_reg(lac_pkg::ADDR_CMD, 32'h400);
    endtask : issue
    task automatic set_all;
        @(posedge clk);
        {wset, tset, sset, rset, lset} <= '1;
        @(posedge clk);
        {wset, tset, sset, rset, lset} <= '0;
    endtask : set_all
    task automatic kick(input logic [7:0] n);
        @(posedge clk);
        len <= n;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
    endtask : kick
    function automatic logic [39:0] lat;
        return {warn, tl, sl, rl, ll};
    endfunction : lat
    // ****
    // scenarios
    // ****
    task automatic t_regs;
        logic [31:0] d;
        rd_reg(lac_pkg::ADDR_CTRL, d);
        chk(d, lac_pkg::CTRL_RESET);
        wr_reg(4'hf, 32'hffff_ffff);
        rd_reg(4'hf, d);
        chk(d, 32'h0);
    endtask : t_regs
    task automatic t_cmds;
        logic [39:0] m [6] = '{40'h10_0000_0000, 40'h00_0000_ffff,
            40'h00_00ff_0000, 40'h00_ff00_0000, 40'h0f_0000_0000,
            40'h0f_ffff_ffff};
        wr_reg(lac_pkg::ADDR_CTRL, 32'h10);
        for (int i = 0; i < 6; i++) begin
            set_all;
            issue(32'h1 << i);
            if (i == 2) chk(rl, 8'hff);
            cyc(20);
            chk(lat(), 40'h1f_ffff_ffff & ~m[i]);
            cyc(60);
        end
    endtask : t_cmds
    task automatic t_alarm;
        wr_reg(lac_pkg::ADDR_LAMP_CFG, 32'h00ff);
        set_all;
        @(posedge clk);
        alarm <= 1'b1;
        cyc(6);
        chk(ll, 16'hff00);
        alarm <= 1'b0;
        cyc(60);
    endtask : t_alarm
    task automatic t_remote;
        logic [31:0] d;
        logic a;
        set_all;
        wr_reg(lac_pkg::ADDR_CMD, 32'h102);
        cyc(6);
        chk(ll, 16'hffff);
        rd_reg(lac_pkg::ADDR_IRQ_STAT, d);
        chk(d[2], 1'b1);
        rd_reg(lac_pkg::ADDR_IRQ_STAT, d);
        chk(d[2], 1'b0);
        wr_reg(lac_pkg::ADDR_CMD, 32'h102);
        wr_reg(lac_pkg::ADDR_IRQ_MASK, 32'h0);
        cyc(2);
        a = irq;
        wr_reg(lac_pkg::ADDR_IRQ_MASK, 32'h7);
        cyc(2);
        chk(irq !== a, 1'b1);
        wr_reg(lac_pkg::ADDR_CTRL, 32'h11);
        issue(32'h102);
        cyc(6);
        chk(ll, 16'h0);
        cyc(60);
    endtask : t_remote
    task automatic t_key;
        int n;
        int g;
        wr_reg(lac_pkg::ADDR_CTRL, 32'h2);
        @(posedge clk);
        mode <= 1'b1;
        set_all;
        kick(8'h05);
        cyc(10);
        chk({menu, ll}, 17'h0ffff);
        mode <= 1'b0;
        kick(8'h1e);
        for (int i = 0; i < 80 && red !== 1'b1; i++) @(posedge clk);
        for (n = 0; n < 100 && red === 1'b1; n++) @(posedge clk);
        for (g = 0; g < 100 && grn === 1'b1; g++) @(posedge clk);
        chk({n[7:0], g[7:0], ll}, {8'(TC), 8'(TC), 16'h0});
        wr_reg(lac_pkg::ADDR_CTRL, 32'h0);
        set_all;
        kick(8'h1e);
        cyc(40);
        chk(ll, 16'hffff);
        kick(8'h05);
        cyc(10);
        chk({menu, ll}, 17'h1ffff);
        wr_reg(lac_pkg::ADDR_CMD, 32'h2);
        cyc(4);
        chk(ll, 16'hffff);
        issue(32'h200);
        cyc(6);
        chk(ll, 16'h0);
        cyc(60);
    endtask : t_key
    task automatic t_scopes;
        logic [39:0] e [3] = '{40'h1f_ffff_0000, 40'h1f_ff00_0000,
            40'h10_0000_0000};
        for (int s = 2; s < 5; s++) begin
            wr_reg(lac_pkg::ADDR_CTRL, 32'(s) << 1);
            set_all;
            kick(8'h1e);
            cyc(34);
            chk({pwp, ll}, 17'h1ffff);
            wr_reg(lac_pkg::ADDR_CMD, 32'h400);
            cyc(20);
            chk(lat(), e[s-2]);
            cyc(60);
        end
    endtask : t_scopes
    task automatic report_and_stop;
        $display("checks=%0d errors=%0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : report_and_stop
    // ****
    // sequence and watchdog
    // ****
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_regs;
        t_cmds;
        t_alarm;
        t_remote;
        t_key;
        t_scopes;
        report_and_stop;
    end
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        report_and_stop;
    end
endmodule : latch_acknowledge_control_tb_top
`default_nettype wire
